/* File: core/ddsc_core.sv */
// Functional notes
// (RULE1) accumulator adds tuning word each clock; here it holds while the sample buffer is full
// (RULE2) cosine lookup feeds 10-bit converter code
// (RULE3) zero tuning word holds current phase
// (RULE4) clear-phase bit forces accumulator to zero
// (RULE5) power-up: active clear set, buffer clear
// (RULE6) multiplier from control_reg_two bits 7:3
// (RULE7) values 4..20 multiply reference clock
// (RULE8) outside 4..20 bypass, loop powered down
// (RULE9) host waits about 1 ms lock
// (RULE10) host keeps multiplied clock within maximum
// (RULE11) osc select pin enables oscillator, buffer
// (RULE12) clock power-down stops clock, oscillator stays
// (RULE13) control_reg_two bit 9 enables crystal buffer
// (RULE14) multiplier independent of clock power-down
// (RULE15) serial port writes and reads registers
// (RULE16) msb-first or lsb-first transfer order
// (RULE17) two-wire or three-wire data pins
// (RULE18) port abort terminates transfer immediately
// (RULE19) traffic ignored unless chip select low
// (RULE20) three-wire output pin carries read data
// (RULE21) writes buffered, committed on update event
// (RULE22) tuning change keeps accumulator phase
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////
// sample buffer with registered output stage
module ddsc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [WIDTH-1:0] i_in_data,
  input wire logic i_in_valid,
  output logic o_in_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic o_out_valid,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic [WIDTH-1:0] out_q, out_d;
  logic vld_q, vld_d;
  logic push, pop;

  // pop into the output stage whenever it is free or drained
  always_comb begin
    push = i_in_valid && (cnt_q < (AW+1)'(DEPTH));
    pop = (cnt_q != '0) && (!vld_q || i_out_ready);
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    out_d = pop ? mem[rd_q] : out_q;
    vld_d = pop ? 1'b1 : (i_out_ready ? 1'b0 : vld_q);
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      out_q <= '0;
      vld_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      vld_q <= vld_d;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_q] <= i_in_data;
    end
  end

  assign o_in_ready = cnt_q < (AW+1)'(DEPTH);
  assign o_out_data = out_q;
  assign o_out_valid = vld_q;
endmodule

////////////////////////////////////////////////////////////////////////
module ddsc_core (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_osc_select_pin,
  input wire logic i_io_update,
  input wire logic i_port_abort,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe,
  output logic o_serial_data_out,
  output logic [ddsc_pkg::DAC_BITS-1:0] o_dac_code,
  output logic o_dac_valid,
  input wire logic i_dac_ready,
  output logic o_pll_enable,
  output logic [4:0] o_pll_mult,
  output logic o_osc_enable,
  output logic o_xtal_buf_en,
  output logic o_synth_clk_en
);
  import ddsc_pkg::*;

  // every check runs on the system clock and sleeps through reset
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);

  // bits of a register at a serial address
  function automatic logic [5:0] reg_bits(input logic [4:0] a);
    unique case (a)
      ADDR_CTRL_ONE: reg_bits = BITS_CTRL_ONE;
      ADDR_CTRL_TWO: reg_bits = BITS_CTRL_TWO;
      ADDR_TUNING: reg_bits = BITS_TUNING;
      default: reg_bits = BITS_OTHER;
    endcase
  endfunction

  // parabolic cosine; cheaper than a table, a few percent error
  function automatic logic [9:0] cos_code(input logic [31:0] p);
    logic signed [9:0] d;
    logic [8:0] m;
    logic [18:0] prod;
    logic [8:0] amp;
    logic pos;
    d = $signed({1'b0, p[30:22]}) - 10'sd256;
    m = d[9] ? 9'(-d) : 9'(d);
    prod = 19'(m) * (19'h200 - 19'(m));
    amp = prod[16] ? DAC_AMP_MAX : prod[15:7];
    pos = d[9] ^ p[31];
    cos_code = pos ? DAC_MID + 10'(amp) : DAC_MID - 10'(amp);
  endfunction

  function automatic logic mult_in_range(input logic [4:0] m);
    mult_in_range = (m >= MULT_MIN) && (m <= MULT_MAX);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // serial port and buffer registers
  ddsc_sp_state_t st_q, st_d;
  logic sclk_q, sclk_d;
  logic [5:0] cnt_q, cnt_d;
  logic [31:0] sh_q, sh_d;
  logic [31:0] rdv_q, rdv_d;
  logic [4:0] addr_q, addr_d;
  logic rd_q, rd_d;
  logic out_q, out_d;
  logic oe_q, oe_d;
  logic sdo_q, sdo_d;
  logic [31:0] c1_buf_q, c1_buf_d;
  logic [23:0] c2_buf_q, c2_buf_d;
  logic [31:0] ftw_buf_q, ftw_buf_d;
  logic [31:0] c1_act_q;
  logic [23:0] c2_act_q;
  logic [31:0] ftw_act_q;
  logic rise, fall, lsb, three_wire;
  logic [31:0] sh_nx, wval;
  logic [5:0] nb;
  logic [7:0] ibyte;

  // sclk is sampled as a plain input; edges found by comparison
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rdv_d = rdv_q;
    addr_d = addr_q;
    rd_d = rd_q;
    out_d = out_q;
    oe_d = 1'b0;
    sdo_d = 1'b0;
    c1_buf_d = c1_buf_q;
    c2_buf_d = c2_buf_q;
    ftw_buf_d = ftw_buf_q;
    sclk_d = i_sclk;
    rise = i_sclk && !sclk_q;
    fall = !i_sclk && sclk_q;
    lsb = c1_act_q[C1_LSB_FIRST];
    three_wire = c1_act_q[C1_SDIO_IN_ONLY];
    nb = reg_bits(addr_q);
    sh_nx = lsb ? {i_sdio, sh_q[31:1]} : {sh_q[30:0], i_sdio}; // [RULE16]
    ibyte = lsb ? sh_nx[31:24] : sh_nx[7:0];
    wval = lsb ? sh_nx >> (6'h20 - nb) : sh_nx;
    if (i_port_abort || i_cs_n) begin // [RULE18] [RULE19]
      st_d = SP_INSTR;
      cnt_d = '0;
      sh_d = '0;
      rd_d = 1'b0;
    end else begin
      unique case (st_q)
        SP_INSTR: begin
          if (rise) begin
            sh_d = sh_nx;
            cnt_d = cnt_q + 6'h01;
            if (cnt_q == 6'(INSTR_BITS - 1)) begin
              st_d = SP_DATA;
              cnt_d = '0;
              sh_d = '0;
              rd_d = ibyte[INSTR_RD_BIT];
              addr_d = ibyte[INSTR_ADDR_HI:0];
              // read back the buffered copy of the register
              unique case (ibyte[INSTR_ADDR_HI:0]) // [RULE15]
                ADDR_CTRL_ONE: rdv_d = c1_buf_q;
                ADDR_CTRL_TWO: rdv_d = {8'h00, c2_buf_q};
                ADDR_TUNING: rdv_d = ftw_buf_q;
                default: rdv_d = '0;
              endcase
            end
          end
        end
        SP_DATA: begin
          if (fall && rd_q) begin
            out_d = lsb ? rdv_q[cnt_q[4:0]]
                        : rdv_q[5'(nb - 6'h01 - cnt_q)]; // [RULE16]
          end
          if (rise) begin
            sh_d = sh_nx;
            cnt_d = cnt_q + 6'h01;
            if (cnt_q == nb - 6'h01) begin
              st_d = SP_INSTR;
              cnt_d = '0;
              sh_d = '0;
              rd_d = 1'b0;
              // writes land in the buffers only
              if (!rd_q) begin // [RULE15] [RULE21]
                unique case (addr_q)
                  ADDR_CTRL_ONE: c1_buf_d = wval;
                  ADDR_CTRL_TWO: c2_buf_d = wval[23:0];
                  ADDR_TUNING: ftw_buf_d = wval;
                  default: ;
                endcase
              end
            end
          end
          // two-wire drives sdio, three-wire uses the output pin
          oe_d = rd_q && !three_wire; // [RULE17]
          sdo_d = rd_q && three_wire && out_d; // [RULE20]
        end
        default: st_d = SP_INSTR;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= SP_INSTR;
      sclk_q <= 1'b0;
      cnt_q <= '0;
      sh_q <= '0;
      rdv_q <= '0;
      addr_q <= '0;
      rd_q <= 1'b0;
      out_q <= 1'b0;
      oe_q <= 1'b0;
      sdo_q <= 1'b0;
      c1_buf_q <= CTRL_ONE_BUF_RST; // [RULE5]
      c2_buf_q <= CTRL_TWO_RST;
      ftw_buf_q <= TUNING_RST;
    end else begin
      st_q <= st_d;
      sclk_q <= sclk_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rdv_q <= rdv_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      out_q <= out_d;
      oe_q <= oe_d;
      sdo_q <= sdo_d;
      c1_buf_q <= c1_buf_d;
      c2_buf_q <= c2_buf_d;
      ftw_buf_q <= ftw_buf_d;
    end
  end

  assign o_sdio = out_q;
  assign o_sdio_oe = oe_q;
  assign o_serial_data_out = sdo_q;

  ////////////////////////////////////////////////////////////////////
  // active registers, clock control and accumulator
  logic [31:0] c1_act_d;
  logic [23:0] c2_act_d;
  logic [31:0] ftw_act_d;
  logic [31:0] acc_q, acc_d;
  logic pll_q, pll_d, osc_q, osc_d, xbuf_q, xbuf_d, clken_q, clken_d;
  logic [4:0] mult_q, mult_d;
  logic fifo_rdy, adv, clr;

  // update event copies every buffer at once
  always_comb begin
    c1_act_d = i_io_update ? c1_buf_q : c1_act_q; // [RULE21] [RULE5]
    c2_act_d = i_io_update ? c2_buf_q : c2_act_q;
    ftw_act_d = i_io_update ? ftw_buf_q : ftw_act_q;
    mult_d = c2_act_q[C2_MULT_HI:C2_MULT_LO]; // [RULE6]
    pll_d = mult_in_range(mult_d); // [RULE7] [RULE8] [RULE14]
    osc_d = i_osc_select_pin; // [RULE11]
    xbuf_d = i_osc_select_pin && c2_act_q[C2_XTAL_OUT_EN]; // [RULE13]
    // oscillator stays on even while the clock is stopped
    clken_d = !c1_act_q[C1_CLK_PWRDN]; // [RULE12]
    clr = c1_act_q[C1_CLEAR_PHASE];
    // full buffer stalls the accumulator so no sample is lost
    adv = fifo_rdy && clken_q;
    // zero tuning word simply adds nothing: phase holds
    if (clr) begin
      acc_d = '0; // [RULE4]
    end else if (adv) begin
      acc_d = acc_q + ftw_act_q; // [RULE1] [RULE3] [RULE22]
    end else begin
      acc_d = acc_q;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      c1_act_q <= CTRL_ONE_ACT_RST; // [RULE5]
      c2_act_q <= CTRL_TWO_RST;
      ftw_act_q <= TUNING_RST;
      acc_q <= '0;
      mult_q <= '0;
      pll_q <= 1'b0;
      osc_q <= 1'b0;
      xbuf_q <= 1'b0;
      clken_q <= 1'b0;
    end else begin
      c1_act_q <= c1_act_d;
      c2_act_q <= c2_act_d;
      ftw_act_q <= ftw_act_d;
      acc_q <= acc_d;
      mult_q <= mult_d;
      pll_q <= pll_d;
      osc_q <= osc_d;
      xbuf_q <= xbuf_d;
      clken_q <= clken_d;
    end
  end

  assign o_pll_enable = pll_q;
  assign o_pll_mult = mult_q;
  assign o_osc_enable = osc_q;
  assign o_xtal_buf_en = xbuf_q;
  assign o_synth_clk_en = clken_q;

  // converter samples pass through the buffer
  ddsc_fifo #(
    .WIDTH(DAC_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_in_data(cos_code(acc_q)), // [RULE2]
    .i_in_valid(adv),
    .o_in_ready(fifo_rdy),
    .o_out_data(o_dac_code),
    .o_out_valid(o_dac_valid),
    .i_out_ready(i_dac_ready)
  );

  ////////////////////////////////////////////////////////////////////
  // checks
  logic upd_seen_q;
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      upd_seen_q <= 1'b0;
    end else begin
      upd_seen_q <= upd_seen_q || i_io_update;
    end
  end

  acc_step_a: assert property ( // [RULE1]
    (adv && !clr) |=> acc_q == $past(acc_q) + $past(ftw_act_q))
    else $error("accumulator did not step by tuning word");
  acc_hold_a: assert property ( // [RULE3]
    (ftw_act_q == '0 && !clr) |=> $stable(acc_q))
    else $error("zero tuning word moved the phase");
  phase_clr_a: assert property ( // [RULE4]
    clr |=> acc_q == '0)
    else $error("clear-phase did not zero accumulator");
  pwrup_clr_a: assert property ( // [RULE5]
    !upd_seen_q |-> clr && acc_q == '0)
    else $error("accumulator not cleared before first update");
  pll_range_a: assert property ( // [RULE8]
    ##1 o_pll_enable == mult_in_range($past(c2_act_q[C2_MULT_HI:C2_MULT_LO])))
    else $error("loop enable disagrees with multiplier");
  clk_stop_a: assert property ( // [RULE12]
    c1_act_q[C1_CLK_PWRDN] |=> !o_synth_clk_en ##0 !adv)
    else $error("clock not stopped by power-down bit");
  xtal_buf_a: assert property ( // [RULE13]
    !i_osc_select_pin |=> !o_xtal_buf_en && !o_osc_enable)
    else $error("crystal buffer on with oscillator off");
  abort_a: assert property ( // [RULE18]
    i_port_abort |=> st_q == SP_INSTR && cnt_q == '0 && !o_sdio_oe)
    else $error("abort did not reset serial port");
  cs_idle_a: assert property ( // [RULE19]
    i_cs_n |=> $stable(ftw_buf_q) && $stable(c1_buf_q))
    else $error("buffer written without chip select");
  sdo_two_a: assert property ( // [RULE20]
    !three_wire |=> !o_serial_data_out)
    else $error("output pin driven in two-wire mode");
  commit_a: assert property ( // [RULE21]
    i_io_update |=> ftw_act_q == $past(ftw_buf_q))
    else $error("update did not commit tuning word");

  write_c: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $changed(ftw_buf_q));
  read_c: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
    o_sdio_oe || o_serial_data_out);
  full_c: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
    !fifo_rdy);
  pll_c: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
    o_pll_enable);
endmodule

/* File: inc/ddsc_pkg.sv */
package ddsc_pkg;
  // serial register addresses
  localparam logic [4:0] ADDR_CTRL_ONE = 5'h00;
  localparam logic [4:0] ADDR_CTRL_TWO = 5'h01;
  localparam logic [4:0] ADDR_TUNING = 5'h04;
  // register widths in bits
  localparam logic [5:0] BITS_CTRL_ONE = 6'h20;
  localparam logic [5:0] BITS_CTRL_TWO = 6'h18;
  localparam logic [5:0] BITS_TUNING = 6'h20;
  localparam logic [5:0] BITS_OTHER = 6'h20;
  // instruction byte fields
  localparam int INSTR_BITS = 8;
  localparam int INSTR_RD_BIT = 7;
  localparam int INSTR_ADDR_HI = 4;
  // control_reg_one field positions
  localparam int C1_LSB_FIRST = 8;
  localparam int C1_SDIO_IN_ONLY = 9;
  localparam int C1_CLEAR_PHASE = 10;
  localparam int C1_CLK_PWRDN = 4;
  // control_reg_two field positions
  localparam int C2_MULT_HI = 7;
  localparam int C2_MULT_LO = 3;
  localparam int C2_XTAL_OUT_EN = 9;
  // multiplier range that engages the loop
  localparam logic [4:0] MULT_MIN = 5'h04;
  localparam logic [4:0] MULT_MAX = 5'h14;
  // loop lock time the host must wait, for reference only
  localparam int PLL_LOCK_US = 1000;
  // reset values; active clear-phase set, buffered copy clear
  localparam logic [31:0] CTRL_ONE_BUF_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_ONE_ACT_RST = 32'h0000_0400;
  localparam logic [23:0] CTRL_TWO_RST = 24'h00_0000;
  localparam logic [31:0] TUNING_RST = 32'h0000_0000;
  // dac path
  localparam int DAC_BITS = 10;
  localparam int FIFO_DEPTH = 32;
  localparam logic [9:0] DAC_MID = 10'h200;
  localparam logic [8:0] DAC_AMP_MAX = 9'h1ff;
  // serial port states
  typedef enum logic [1:0] {
    SP_INSTR = 2'b01,
    SP_DATA = 2'b10
  } ddsc_sp_state_t;
endpackage

/* File: verification/dds_core_clock_select_tb.sv */
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////
module dds_core_clock_select_tb;
  import ddsc_pkg::*;
  logic clk, nrst, osc_pin, io_upd, dac_rdy;
  logic cs_n, sclk, sdio_w, abort_p, sdio_d, sdio_oe, serial_data_out;
  logic [DAC_BITS-1:0] dac_code, c, prev;
  logic dac_valid, pll_en, osc_en, xbuf_en, clk_en, lsb, three;
  logic [4:0] pll_mult;
  logic [31:0] rd;
  int fail_count, checks, n, m;

  ddsc_core ddsc_core_i (
    .i_sys_clk(clk), .i_nrst(nrst), .i_osc_select_pin(osc_pin),
    .i_io_update(io_upd), .i_port_abort(abort_p), .i_cs_n(cs_n),
    .i_sclk(sclk), .i_sdio(sdio_w), .o_sdio(sdio_d), .o_sdio_oe(sdio_oe),
    .o_serial_data_out(serial_data_out), .o_dac_code(dac_code),
    .o_dac_valid(dac_valid), .i_dac_ready(dac_rdy), .o_pll_enable(pll_en),
    .o_pll_mult(pll_mult), .o_osc_enable(osc_en),
    .o_xtal_buf_en(xbuf_en), .o_synth_clk_en(clk_en)
  );

  ddsc_host ddsc_host_i (
    .i_sys_clk(clk), .i_sdio_dev(sdio_d), .i_sdio_oe(sdio_oe),
    .i_serial_data_out(serial_data_out), .o_cs_n(cs_n), .o_sclk(sclk),
    .o_sdio(sdio_w), .o_port_abort(abort_p)
  );

  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic close_out;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_code(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // frame wrapper; length follows the register addressed
  task automatic xf(input logic [7:0] ins, input logic [31:0] wd,
                    input logic sel, input int cut);
    int nb;
    begin
      nb = (ins[4:0] == ADDR_CTRL_TWO) ? int'(BITS_CTRL_TWO) : 32;
      ddsc_host_i.xfer(ins, wd, nb, lsb, three, sel, cut, rd);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    xf({3'b000, a}, d, 1'b1, 0);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    xf({3'b100, a}, 32'h0, 1'b1, 0);
    cmp_word(rd, exp);
  endtask

  // commit pulse, then let the active copy reach the outputs
  task automatic commit;
    io_upd = 1'b1;
    tick(1);
    io_upd = 1'b0;
    tick(3);
  endtask

  // sample taken at the edge where valid and ready meet
  task automatic get_code(output logic [9:0] code);
    int w;
    begin
      w = 0;
      while (dac_valid !== 1'b1 && w < 100) begin
        tick(1);
        w++;
      end
      code = dac_code;
      tick(1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // hang guard, well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    close_out;
  end

  // main sequence
  initial begin
    nrst = 1'b0;
    osc_pin = 1'b1;
    io_upd = 1'b0;
    dac_rdy = 1'b1;
    lsb = 1'b0;
    three = 1'b0;
    fail_count = 0;
    checks = 0;
    tick(20);
    nrst = 1'b1;
    tick(3);
    cmp_word(32'({clk_en, osc_en}), 32'h3);
    cmp_word(32'({pll_mult, pll_en, xbuf_en}), 32'h0);
    rdchk(ADDR_CTRL_ONE, CTRL_ONE_BUF_RST);
    rdchk(ADDR_CTRL_TWO, 32'(CTRL_TWO_RST));
    get_code(c);
    cmp_code(c, 10'h3ff);
    // half-turn step alternates the two cosine extremes
    wr(ADDR_TUNING, 32'h8000_0000);
    rdchk(ADDR_TUNING, 32'h8000_0000);
    get_code(c);
    cmp_code(c, 10'h3ff);
    commit;
    tick(40);
    get_code(prev);
    cmp_code(prev, prev[9] ? 10'h3ff : 10'h001);
    for (n = 0; n < 6; n++) begin
      get_code(c);
      cmp_code(c, prev ^ 10'h3fe);
      prev = c;
    end
    // zero step holds whatever phase it stopped on
    wr(ADDR_TUNING, 32'h0);
    commit;
    tick(40);
    get_code(prev);
    for (n = 0; n < 5; n++) begin
      get_code(c);
      cmp_code(c, prev);
    end
    wr(ADDR_CTRL_ONE, 32'h400);
    commit;
    tick(40);
    get_code(c);
    cmp_code(c, 10'h3ff);
    wr(ADDR_TUNING, 32'h8000_0000);
    wr(ADDR_CTRL_ONE, 32'h0);
    commit;
    // stall the consumer until full, stop the clock, then drain
    dac_rdy = 1'b0;
    tick(60);
    wr(ADDR_CTRL_ONE, 32'h10);
    commit;
    cmp_word(32'(clk_en), 32'h0);
    dac_rdy = 1'b1;
    n = 0;
    while (dac_valid === 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    cmp_word(32'(n), 32'(FIFO_DEPTH + 1));
    tick(5);
    cmp_word(32'(dac_valid), 32'h0);
    wr(ADDR_CTRL_TWO, 32'h50);
    commit;
    cmp_word(32'({pll_mult, pll_en, clk_en}), 32'h2a);
    // every multiplier code; 20 MHz reference times 20 stays in range
    for (m = 0; m < 32; m++) begin
      osc_pin = m[0];
      wr(ADDR_CTRL_TWO, {22'h0, m[1], 1'b0, m[4:0], 3'h0});
      commit;
      cmp_word(32'(pll_mult), 32'(m[4:0]));
      cmp_word(32'(pll_en), 32'(m >= 4 && m <= 20));
      cmp_word(32'(osc_en), 32'(m[0]));
      cmp_word(32'(xbuf_en), 32'(m[0] & m[1]));
    end
    // let the loop lock before the clock is trusted again
    tick(PLL_LOCK_US * 20); // 20 cycles to the microsecond
    // refused traffic leaves the buffer untouched
    xf({3'b000, ADDR_TUNING}, 32'h1234_5678, 1'b0, 0);
    rdchk(ADDR_TUNING, 32'h8000_0000);
    xf({3'b000, ADDR_TUNING}, 32'hdead_beef, 1'b1, 20);
    rdchk(ADDR_TUNING, 32'h8000_0000);
    wr(ADDR_TUNING, 32'h0bad_cafe);
    rdchk(ADDR_TUNING, 32'h0bad_cafe);
    wr(5'h07, 32'hffff_ffff);
    rdchk(5'h07, 32'h0);
    // order and wire mode switch only at commit
    wr(ADDR_CTRL_ONE, 32'h100);
    commit;
    lsb = 1'b1;
    wr(ADDR_TUNING, 32'h1357_2468);
    rdchk(ADDR_TUNING, 32'h1357_2468);
    wr(ADDR_CTRL_ONE, 32'h300);
    commit;
    three = 1'b1;
    rdchk(ADDR_TUNING, 32'h1357_2468);
    cmp_word(32'(ddsc_host_i.bad_count), 32'h0);
    close_out;
  end
endmodule

/* File: verification/ddsc_host.sv */
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////
// host side of the serial configuration port
module ddsc_host (
  input wire logic i_sys_clk,
  input wire logic i_sdio_dev,
  input wire logic i_sdio_oe,
  input wire logic i_serial_data_out,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_sdio,
  output logic o_port_abort
);
  logic drv;
  int bad_count;

  // wire level: the device wins while it drives
  assign o_sdio = i_sdio_oe ? i_sdio_dev : drv;

  // idle frame, clock parked low
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_port_abort = 1'b0;
    drv = 1'b0;
    bad_count = 0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  // one frame; cut above zero raises abort before that bit
  task automatic xfer(input logic [7:0] ins, input logic [31:0] wd,
                      input int nb, input logic lsb, input logic three,
                      input logic sel, input int cut,
                      output logic [31:0] rd);
    int i;
    int k;
    logic rdn;
    begin
      rd = 32'h0;
      rdn = ins[7];
      o_cs_n = !sel;
      for (i = 0; i < 8 + nb; i++) begin
        if (cut != 0 && cut == i) begin
          o_port_abort = 1'b1;
          tick(3);
          o_port_abort = 1'b0;
          break;
        end
        if (i < 8) begin
          k = lsb ? i : 7 - i;
        end else begin
          k = lsb ? i - 8 : nb - 1 - (i - 8);
        end
        o_sclk = 1'b0;
        // released line toggles so a stale level never reads as data
        drv = (i >= 8 && rdn) ? ~drv : ((i < 8) ? ins[k] : wd[k]);
        tick(3); // both sclk phases kept above two sys cycles
        o_sclk = 1'b1;
        if (i >= 8 && rdn) begin
          rd[k] = three ? i_serial_data_out : o_sdio;
          if (three ? i_sdio_oe : (!i_sdio_oe || i_serial_data_out)) begin
            bad_count++;
          end
        end
        tick(3);
      end
      o_sclk = 1'b0;
      drv = ~drv;
      // a cut frame keeps select low: only the abort can end it
      if (cut == 0) begin
        o_cs_n = 1'b1;
      end
      tick(2);
    end
  endtask
endmodule
